// [logic/asram_ctrl.sv]
// Host controller for an asynchronous 4096 x 4 static RAM with shared data pins.
// Assumes a 125 MHz core_clk and an SRAM whose pins connect straight to ours.
//
// How it works
// - Reads keep write enable high throughout
// - Address valid no later than select falling
// - Write happens while both strobes are low
// - Write ends at first strobe rising
// - Never lower write enable under select
// - Stop driving before device drives again
`timescale 1ns/1ns
`include "asram_defs.svh"
module asram_ctrl (
    // Clock, reset and enable
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Request and response
    input  wire asram_pkg::asram_req_t    req,
    output logic                          req_ready,
    output asram_pkg::asram_rsp_t         rsp,
    // SRAM pins
    output logic [`ASRAM_ADDR_W-1:0]      sram_addr,
    output logic                          sram_cs_n,
    output logic                          sram_we_n,
    output logic [`ASRAM_DATA_W-1:0]      sram_dq_wr,
    output logic                          sram_dq_oe,
    input  wire logic [`ASRAM_DATA_W-1:0] sram_dq_pin
);
    asram_pkg::asram_regs_t   r_q;
    asram_pkg::asram_regs_t   r_d;
    logic [`ASRAM_DATA_W-1:0] dq_sync;

    asram_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_raw  (sram_dq_pin),
        .pin_sync (dq_sync)
    );

    // Requests are only taken between cycles, so the pins never change mid-access
    assign req_ready = ce && (r_q.state == asram_pkg::ASRAM_IDLE);

    // Every timed state ends on the same counter decode
    function automatic logic cnt_done(input logic [3:0] cnt_val);
        return cnt_val == `ASRAM_CNT_RST;
    endfunction : cnt_done

    always_comb begin
        r_d = r_q;
        if (ce) begin
            // Answer is a one-cycle pulse; it is frozen with the rest while ce is low
            r_d.rsp.valid = 1'h0;
            case (r_q.state)
                asram_pkg::ASRAM_IDLE: begin
                    if (req.valid) begin
                        // Address and select change on the same edge
                        r_d.pin.addr = req.addr;
                        r_d.pin.cs_n = 1'h0;
                        if (req.write) begin
                            // Both strobes fall together so the device never drives
                            r_d.pin.we_n  = 1'h0;
                            r_d.pin.dq_o  = req.wdata;
                            r_d.pin.dq_oe = 1'h1;
                            r_d.cnt       = 4'(`ASRAM_WP_CYC - 1);
                            r_d.state     = asram_pkg::ASRAM_WRITE;
                        end else begin
                            // Two extra cycles cover the pin synchroniser
                            r_d.pin.we_n  = 1'h1;
                            r_d.pin.dq_oe = 1'h0;
                            r_d.cnt       = 4'(`ASRAM_RC_CYC + `ASRAM_SYNC_CYC - 1);
                            r_d.state     = asram_pkg::ASRAM_READ;
                        end
                    end
                end
                asram_pkg::ASRAM_READ: begin
                    if (cnt_done(r_q.cnt)) begin
                        r_d.rsp.valid = 1'h1;
                        r_d.rsp.rdata = dq_sync;
                        r_d.pin.cs_n  = 1'h1;
                        r_d.cnt       = 4'(`ASRAM_HZ_CYC - 1);
                        r_d.state     = asram_pkg::ASRAM_TURN;
                    end else begin
                        r_d.cnt = r_q.cnt - 4'h1;
                    end
                end
                asram_pkg::ASRAM_WRITE: begin
                    if (cnt_done(r_q.cnt)) begin
                        // Both strobes rise together, so the device stays off
                        r_d.pin.cs_n = 1'h1;
                        r_d.pin.we_n = 1'h1;
                        r_d.cnt      = 4'(`ASRAM_WR_CYC - 1);
                        r_d.state    = asram_pkg::ASRAM_RECOV;
                    end else begin
                        r_d.cnt = r_q.cnt - 4'h1;
                    end
                end
                asram_pkg::ASRAM_RECOV: begin
                    // Data and address held one cycle past the strobes
                    if (cnt_done(r_q.cnt)) begin
                        r_d.pin.dq_oe = 1'h0;
                        r_d.state     = asram_pkg::ASRAM_IDLE;
                    end else begin
                        r_d.cnt = r_q.cnt - 4'h1;
                    end
                end
                asram_pkg::ASRAM_TURN: begin
                    // Device may still drive for its release time after a read
                    if (cnt_done(r_q.cnt)) begin
                        r_d.state = asram_pkg::ASRAM_IDLE;
                    end else begin
                        r_d.cnt = r_q.cnt - 4'h1;
                    end
                end
                default: begin
                    r_d.state     = asram_pkg::ASRAM_IDLE;
                    r_d.pin.cs_n  = 1'h1;
                    r_d.pin.we_n  = 1'h1;
                    r_d.pin.dq_oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q.state     <= asram_pkg::ASRAM_IDLE;
            r_q.cnt       <= `ASRAM_CNT_RST;
            r_q.pin.addr  <= `ASRAM_ADDR_RST;
            r_q.pin.cs_n  <= 1'h1;
            r_q.pin.we_n  <= 1'h1;
            r_q.pin.dq_o  <= `ASRAM_DATA_RST;
            r_q.pin.dq_oe <= 1'h0;
            r_q.rsp.valid <= 1'h0;
            r_q.rsp.rdata <= `ASRAM_DATA_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign rsp        = r_q.rsp;
    assign sram_addr  = r_q.pin.addr;
    assign sram_cs_n  = r_q.pin.cs_n;
    assign sram_we_n  = r_q.pin.we_n;
    assign sram_dq_wr = r_q.pin.dq_o;
    assign sram_dq_oe = r_q.pin.dq_oe;

    // Checks below assume ce stays high through an access
    a_read_we_held: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        ($fell(sram_cs_n) && sram_we_n) |-> (sram_we_n && !sram_cs_n) [*7]
    ) else $error("write enable dropped or select lost during a read");

    a_read_answer: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        ($fell(sram_cs_n) && sram_we_n) |-> ##7 (rsp.valid && sram_cs_n)
    ) else $error("read answer not seven cycles after select fell");

    a_addr_stable: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        (!sram_cs_n && $past(!sram_cs_n)) |-> $stable(sram_addr)
    ) else $error("address changed while select low");

    a_write_pulse: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        $fell(sram_we_n) |-> (!sram_cs_n && !sram_we_n && sram_dq_oe) [*4]
            ##1 (sram_cs_n && sram_we_n && sram_dq_oe)
    ) else $error("write pulse length or data drive wrong");

    a_write_end_both: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        $rose(sram_we_n) |-> $rose(sram_cs_n)
    ) else $error("write ended with select still low");

    a_we_under_cs: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        $fell(sram_we_n) |-> $fell(sram_cs_n)
    ) else $error("write enable fell while select already low");

    a_no_drive_read: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        (!sram_cs_n && sram_we_n) |-> !sram_dq_oe
    ) else $error("host drives data while the device may drive");

    a_turnaround: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        ($rose(sram_cs_n) && !sram_dq_oe) |-> !sram_dq_oe [*3]
    ) else $error("host drove data too soon after a read");

    a_addr_after_wr: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        $rose(sram_we_n) |-> $stable(sram_addr) ##1 $stable(sram_addr)
    ) else $error("address moved at the end of a write");

    a_ready_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        (req_ready && req.valid && req.write) |=> !req_ready [*5]
    ) else $error("new request accepted inside a write cycle");

    a_rsp_one_cycle: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        rsp.valid |=> !rsp.valid
    ) else $error("read answer stood longer than one cycle");

    a_we_needs_cs: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        sram_cs_n |-> sram_we_n
    ) else $error("write enable low while deselected");

    a_drive_in_write: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        (sram_dq_oe && !sram_cs_n) |-> !sram_we_n
    ) else $error("host drives data while selected outside a write");

    a_wdata_held: assert property (
        @(posedge core_clk) disable iff (!rst_n || !ce)
        (!sram_we_n && !$past(sram_we_n)) |-> $stable(sram_dq_wr)
    ) else $error("write data moved inside the write pulse");
endmodule : asram_ctrl

// [logic/asram_defs.svh]
// Constants for the asynchronous 4K x 4 SRAM host controller.
// Assumes a single core clock of 125 MHz; all times are in ns.
`ifndef ASRAM_DEFS_SVH
`define ASRAM_DEFS_SVH

`define ASRAM_ADDR_W        12
`define ASRAM_DATA_W        4
`define ASRAM_ADDR_RST      12'h000
`define ASRAM_DATA_RST      4'h0
`define ASRAM_CNT_RST       4'h0

`define ASRAM_CLK_PERIOD_NS 8
`define ASRAM_READ_CYCLE_TIME_NS  35
`define ASRAM_T_WP_NS       30
`define ASRAM_T_WC_NS       35
`define ASRAM_T_HZ_NS       20
`define ASRAM_SYNC_CYC      2

// Least times round up to whole clock periods
`define ASRAM_CEIL(ns) (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_RC_CYC  `ASRAM_CEIL(`ASRAM_READ_CYCLE_TIME_NS)
`define ASRAM_WP_CYC  `ASRAM_CEIL(`ASRAM_T_WP_NS)
`define ASRAM_WR_CYC  (`ASRAM_CEIL(`ASRAM_T_WC_NS) - `ASRAM_WP_CYC)
`define ASRAM_HZ_CYC  `ASRAM_CEIL(`ASRAM_T_HZ_NS)

`endif

// [logic/asram_pkg.sv]
// Types shared by the SRAM host controller and its pin synchroniser.
// Widths come from asram_defs.svh.
`include "asram_defs.svh"
package asram_pkg;

    typedef struct packed {
        logic                     valid;
        logic                     write;
        logic [`ASRAM_ADDR_W-1:0] addr;
        logic [`ASRAM_DATA_W-1:0] wdata;
    } asram_req_t;

    typedef struct packed {
        logic                     valid;
        logic [`ASRAM_DATA_W-1:0] rdata;
    } asram_rsp_t;

    typedef struct packed {
        logic [`ASRAM_ADDR_W-1:0] addr;
        logic                     cs_n;
        logic                     we_n;
        logic [`ASRAM_DATA_W-1:0] dq_o;
        logic                     dq_oe;
    } asram_pin_t;

    typedef enum logic [2:0] {
        ASRAM_IDLE,
        ASRAM_READ,
        ASRAM_WRITE,
        ASRAM_RECOV,
        ASRAM_TURN
    } asram_state_t;

    typedef struct packed {
        asram_state_t state;
        logic [3:0]   cnt;
        asram_pin_t   pin;
        asram_rsp_t   rsp;
    } asram_regs_t;

    typedef struct packed {
        logic [`ASRAM_DATA_W-1:0] s1;
        logic [`ASRAM_DATA_W-1:0] s2;
    } asram_sync_t;

endpackage : asram_pkg

// [logic/asram_sync.sv]
// Two-flop synchroniser for the SRAM data pins.
// The pins change with no regard to core_clk; only stage two is read outside.
`timescale 1ns/1ns
`include "asram_defs.svh"
module asram_sync (
    // Clock, reset and enable
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Pin side and synchronised side
    input  wire logic [`ASRAM_DATA_W-1:0] pin_raw,
    output logic      [`ASRAM_DATA_W-1:0] pin_sync
);
    asram_pkg::asram_sync_t q_q;
    asram_pkg::asram_sync_t q_d;

    always_comb begin
        q_d = q_q;
        if (ce) begin
            q_d.s1 = pin_raw;
            q_d.s2 = q_q.s1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q.s1 <= `ASRAM_DATA_RST;
            q_q.s2 <= `ASRAM_DATA_RST;
        end else begin
            q_q <= q_d;
        end
    end

    genvar i;
    for (i = 0; i < `ASRAM_DATA_W; i++) begin : g_bit
        assign pin_sync[i] = q_q.s2[i];
    end
endmodule : asram_sync

// [test/asram_mem_model.sv]
// Behavioural 4096 x 4 static RAM standing on the controller's pins.
// Assumes the bench resolves the shared data wire and feeds it back as dq_bus.
`timescale 1ns/1ns
`include "asram_defs.svh"
module asram_mem_model #(
    parameter int ACC_NS = 30
) (
    // Control and address
    input  wire logic [`ASRAM_ADDR_W-1:0] addr,
    input  wire logic                     cs_n,
    input  wire logic                     we_n,
    // Shared data wire
    input  wire logic [`ASRAM_DATA_W-1:0] dq_bus,
    output logic      [`ASRAM_DATA_W-1:0] dq_drv,
    output logic                          dq_en
);
    logic [`ASRAM_DATA_W-1:0] mem [0:4095];
    logic [`ASRAM_ADDR_W-1:0] wr_addr;
    logic [`ASRAM_DATA_W-1:0] wr_data;
    logic                     wr_act = 1'h0;
    wire  [`ASRAM_ADDR_W+1:0] key_dly;

    // Inertial delay: the copy catches up only once the pins stood still for the access time
    assign #(ACC_NS) key_dly = {addr, cs_n, we_n};
    // Drives only when selected with write enable high
    assign dq_en  = !cs_n && we_n;
    // Inverted data while settling, so an early sample fails; echo after write
    assign dq_drv = (key_dly === {addr, cs_n, we_n}) ? mem[addr] : ~mem[addr];

    // Cell follows the wire during the overlap; the first strobe to rise closes it
    always @(addr, cs_n, we_n, dq_bus) begin
        if (!cs_n && !we_n) begin
            wr_act  = 1'h1;
            wr_addr = addr;
            wr_data = dq_bus;
        end else if (wr_act) begin
            mem[wr_addr] = wr_data;
            wr_act       = 1'h0;
        end
    end
endmodule : asram_mem_model

// [test/tb_top.sv]
// Self-checking bench for the SRAM host controller.
// Assumes the behavioural RAM model; the undriven wire is fed a moving pattern.
`timescale 1ns/1ns
`include "asram_defs.svh"
module tb_top;
    logic                     core_clk   = 1'h0;
    logic                     rst_n      = 1'h0;
    logic                     ce         = 1'h1;
    asram_pkg::asram_req_t    req        = '0;
    asram_pkg::asram_rsp_t    rsp;
    logic                     req_ready;
    logic                     cs_n;
    logic                     we_n;
    logic                     dq_oe;
    logic                     mdl_en;
    logic [`ASRAM_ADDR_W-1:0] addr;
    logic [`ASRAM_DATA_W-1:0] dq_o;
    logic [`ASRAM_DATA_W-1:0] dq_i;
    logic [`ASRAM_DATA_W-1:0] mdl_dq;
    logic [`ASRAM_DATA_W-1:0] wander     = 4'h0;
    logic [11:0]              adr_tab [4] = '{12'h000, 12'hFFF, 12'h5A5, 12'h800};
    logic [3:0]               dat_tab [4] = '{4'hF, 4'h0, 4'hA, 4'h5};
    int                       num_errors = 0;
    int                       cmp_count  = 0;

    always #4 core_clk = ~core_clk;
    // Released wire keeps moving so a stale sample cannot pass
    always @(posedge core_clk) wander <= wander + 4'h3;
    assign dq_i = dq_oe ? dq_o : (mdl_en ? mdl_dq : wander);

    asram_ctrl i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .req(req), .req_ready(req_ready),
        .rsp(rsp), .sram_addr(addr), .sram_cs_n(cs_n), .sram_we_n(we_n),
        .sram_dq_wr(dq_o), .sram_dq_oe(dq_oe), .sram_dq_pin(dq_i));
    asram_mem_model #(.ACC_NS(`ASRAM_READ_CYCLE_TIME_NS)) i_mem (
        .addr(addr), .cs_n(cs_n), .we_n(we_n), .dq_bus(dq_i), .dq_drv(mdl_dq), .dq_en(mdl_en));

    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    // Contention on the shared wire is never acceptable
    always @(negedge core_clk) begin
        if (rst_n && dq_oe && mdl_en) check("dq contention", 20'h0, 20'h1);
    end

    // Holds the request until an edge takes it; returns just after that edge
    task automatic offer(input logic wr, input logic [11:0] a, input logic [3:0] d);
        int n;
        n = 0;
        req <= '{valid: 1'h1, write: wr, addr: a, wdata: d};
        while (req_ready !== 1'h1) begin
            tick();
            n++;
            if (n > 20) begin
                check("req_ready wait", 20'h1, 20'h0);
                wrap_up();
            end
        end
        tick();
        req.valid <= 1'h0;
    endtask : offer

    task automatic do_write(input logic [11:0] a, input logic [3:0] d);
        offer(1'h1, a, d);
        repeat (4) begin
            check("write pins", {3'h1, d, a}, {cs_n, we_n, dq_oe, dq_o, addr});
            tick();
        end
        check("write end", {2'h3, a}, {cs_n, we_n, addr});
        tick();
        check("write release", 20'h1, {dq_oe, req_ready});
    endtask : do_write

    // Optional stall drops the clock enable in mid-read; the access must freeze
    task automatic do_read(input logic [11:0] a, input logic [3:0] d, input logic stall);
        int n;
        int nsel;
        n = 0;
        nsel = 0;
        offer(1'h0, a, 4'h0);
        if (stall) begin
            ce <= 1'h0;
            repeat (3) tick();
            check("frozen select", {1'h0, a}, {cs_n, addr});
            ce <= 1'h1;
        end
        while (rsp.valid !== 1'h1) begin
            check("read pins", 20'h2, {we_n, dq_oe});
            if (cs_n === 1'h0) begin
                check("read address", a, addr);
                nsel++;
            end
            tick();
            n++;
            if (n > 12) begin
                check("read answer wait", 20'h1, 20'h0);
                wrap_up();
            end
        end
        check("read data", d, rsp.rdata);
        check("select long enough", 20'h1, 20'(nsel >= 5));
        tick();
        check("answer pulse", 20'h0, rsp.valid);
    endtask : do_read

    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        check("reset pins", 20'h19, {cs_n, we_n, dq_oe, rsp.valid, req_ready});
        rst_n = 1'h1;
        for (int i = 0; i < 4; i++) do_write(adr_tab[i], dat_tab[i]);
        for (int i = 0; i < 4; i++) do_read(adr_tab[i], dat_tab[i], 1'h0);
        do_write(12'h5A5, 4'h3);
        do_read(12'h5A5, 4'h3, 1'h1);
        rst_n = 1'h0;
        tick();
        check("second reset pins", 20'h19, {cs_n, we_n, dq_oe, rsp.valid, req_ready});
        rst_n = 1'h1;
        do_read(12'hFFF, 4'h0, 1'h0);
        wrap_up();
    end
endmodule : tb_top
